/* File: design/lar_pkg.sv */
// Package of constants and types for the level alarm relay logic
package lar_pkg;
  localparam int LEVEL_W = 16;
  localparam int RESP_W = 16;
  localparam int NUM_RELAYS = 3;
  // Level full scale is 100.0 percent in tenths
  localparam logic [15:0] FULL_SCALE = 16'h03e8;
  localparam logic [15:0] DEADBAND_MIN = 16'h0001;
  localparam logic [15:0] DEADBAND_RST = 16'h0001;
  localparam logic [15:0] SETPOINT_RST = 16'h0000;
  localparam logic [15:0] RESP_RST = 16'h0000;
  localparam logic [15:0] MAX_FLOW_RST = 16'h0000;
  localparam logic [2:0] DP_RST = 3'h0;
  // Response time unit is 1 ms
  localparam int RESP_UNIT_NS = 1000000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_CYCLES = RESP_UNIT_NS / CLK_PERIOD_NS;
  // Acknowledge flash time in ms
  localparam int ACK_FLASH_MS = 500;
  // Field select codes for keypad writes
  localparam logic [2:0] FLD_SETPOINT = 3'h0;
  localparam logic [2:0] FLD_DEADBAND = 3'h1;
  localparam logic [2:0] FLD_RESP = 3'h2;
  localparam logic [2:0] FLD_MAX_FLOW = 3'h3;
  localparam logic [2:0] FLD_DP = 3'h4;
  typedef enum logic [1:0] {
    LAR_DISP_LEVEL = 2'b01,
    LAR_DISP_CONV = 2'b10
  } lar_disp_t;
endpackage : lar_pkg

/* File: design/lar_relay_chan.sv */
// One relay channel: compare, hysteresis and response delay
`timescale 1ns/1ps
module lar_relay_chan #(
  parameter int LEVEL_W = lar_pkg::LEVEL_W,
  parameter int RESP_W = lar_pkg::RESP_W
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic tick_i,
  // Settings
  input wire logic rising_level_trip_i,
  input wire logic [LEVEL_W-1:0] setpoint_i,
  input wire logic [LEVEL_W-1:0] deadband_i,
  input wire logic [RESP_W-1:0] resp_i,
  input wire logic [LEVEL_W-1:0] level_i,
  // Result
  output logic alarm_o
);
  logic alarm_r;
  logic alarm_nxt;
  logic [RESP_W-1:0] timer_r;
  logic [RESP_W-1:0] timer_nxt;
  logic at_sp;
  logic clear;
  logic [LEVEL_W:0] upper;
  logic [LEVEL_W:0] lower;

  always_comb begin
    upper = {1'b0, setpoint_i} + {1'b0, deadband_i};
    lower = {1'b0, setpoint_i} - {1'b0, deadband_i};
    if (rising_level_trip_i) begin
      at_sp = level_i >= setpoint_i;
      // Underflowed lower bound means reset never reachable below zero
      clear = !lower[LEVEL_W] && ({1'b0, level_i} < lower);
    end else begin
      at_sp = level_i <= setpoint_i;
      clear = {1'b0, level_i} > upper;
    end
    alarm_nxt = alarm_r;
    timer_nxt = timer_r;
    if (alarm_r) begin
      if (clear) begin
        alarm_nxt = 1'b0;
      end
      timer_nxt = '0;
    end else if (!at_sp) begin
      timer_nxt = '0;
    end else if (timer_r >= resp_i) begin
      alarm_nxt = 1'b1;
      timer_nxt = '0;
    end else if (tick_i) begin
      timer_nxt = timer_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alarm_r <= 1'b0;
      timer_r <= '0;
    end else if (clk_en_i) begin
      alarm_r <= alarm_nxt;
      timer_r <= timer_nxt;
    end
  end

  assign alarm_o = alarm_r;
endmodule : lar_relay_chan

/* File: design/lar_top.sv */
// Top of the level alarm relay logic with keypad settings store
`timescale 1ns/1ps
module lar_top #(
  parameter int LEVEL_W = lar_pkg::LEVEL_W,
  parameter int RESP_W = lar_pkg::RESP_W,
  parameter int TICK_CYCLES = lar_pkg::TICK_CYCLES,
  parameter int ACK_CYCLES = lar_pkg::ACK_FLASH_MS * lar_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // Measured levels
  input wire logic [LEVEL_W-1:0] pct_level_i,
  input wire logic [LEVEL_W-1:0] conv_level_i,
  // Slide switches, asynchronous
  input wire logic converted_level_source_i,
  input wire logic [2:0] rising_level_trip_i,
  input wire logic diag_relay_c_i,
  // Fault inputs, asynchronous
  input wire logic diag_error_i,
  input wire logic power_fail_i,
  // Keypad entry, same clock
  input wire logic key_enter_i,
  input wire logic [1:0] key_relay_i,
  input wire logic [2:0] key_field_i,
  input wire logic [LEVEL_W-1:0] key_value_i,
  input wire logic menu_exit_key_i,
  input wire logic display_variable_key_i,
  input wire logic linearization_menu_i,
  input wire logic decimal_point_menu_i,
  // Relay coils, high is energized
  output logic [2:0] relay_coil_o,
  // Display status
  output logic ack_flash_o,
  output logic entry_reject_o,
  output logic table_stored_o,
  output logic show_converted_o,
  output logic [2:0] decimal_point_o,
  output logic [LEVEL_W-1:0] max_flow_o
);
  // Three-stage synchronisers for pins
  logic [6:0] sync1_r;
  logic [6:0] sync2_r;
  logic [6:0] sync3_r;
  logic [6:0] pin_r;
  logic [6:0] pin_nxt;
  logic [6:0] pins;

  assign pins = {power_fail_i, diag_error_i, diag_relay_c_i, rising_level_trip_i, converted_level_source_i};

  always_comb begin
    pin_nxt = pin_r;
    for (int i = 0; i < 7; i++) begin
      if (sync2_r[i] == sync3_r[i]) begin
        pin_nxt[i] = sync3_r[i];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      pin_r <= 7'h40;
    end else if (clk_en_i) begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      pin_r <= pin_nxt;
    end
  end

  logic conv_src;
  logic [2:0] rise_sw;
  logic diag_c;
  logic diag_err;
  logic pwr_fail;
  assign conv_src = pin_r[0];
  assign rise_sw = pin_r[3:1];
  assign diag_c = pin_r[4];
  assign diag_err = pin_r[5];
  assign pwr_fail = pin_r[6];

  // Settings store
  logic [LEVEL_W-1:0] sp_r [3];
  logic [LEVEL_W-1:0] sp_nxt [3];
  logic [LEVEL_W-1:0] db_r [3];
  logic [LEVEL_W-1:0] db_nxt [3];
  logic [RESP_W-1:0] rt_r [3];
  logic [RESP_W-1:0] rt_nxt [3];
  logic [LEVEL_W-1:0] flow_r;
  logic [LEVEL_W-1:0] flow_nxt;
  logic [2:0] dp_r;
  logic [2:0] dp_nxt;
  logic reject_r;
  logic reject_nxt;
  logic ack_start;

  function automatic logic db_ok(input logic [LEVEL_W-1:0] v);
    db_ok = (v >= lar_pkg::DEADBAND_MIN) && (v <= lar_pkg::FULL_SCALE);
  endfunction : db_ok

  // Stored values are raw; source switch never touches them
  always_comb begin
    sp_nxt = sp_r;
    db_nxt = db_r;
    rt_nxt = rt_r;
    flow_nxt = flow_r;
    dp_nxt = dp_r;
    reject_nxt = 1'b0;
    ack_start = 1'b0;
    if (key_enter_i && key_relay_i < 2'd3) begin
      case (key_field_i)
        lar_pkg::FLD_SETPOINT: begin
          sp_nxt[key_relay_i] = key_value_i;
          ack_start = 1'b1;
        end
        lar_pkg::FLD_DEADBAND: begin
          if (db_ok(key_value_i)) begin
            db_nxt[key_relay_i] = key_value_i;
            ack_start = 1'b1;
          end else begin
            reject_nxt = 1'b1;
          end
        end
        lar_pkg::FLD_RESP: begin
          rt_nxt[key_relay_i] = RESP_W'(key_value_i);
          ack_start = 1'b1;
        end
        lar_pkg::FLD_MAX_FLOW: begin
          if (linearization_menu_i) begin
            flow_nxt = key_value_i;
            ack_start = 1'b1;
          end
        end
        lar_pkg::FLD_DP: begin
          if (decimal_point_menu_i) begin
            dp_nxt = key_value_i[2:0];
            ack_start = 1'b1;
          end
        end
        default: begin
          reject_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 3; i++) begin
        sp_r[i] <= lar_pkg::SETPOINT_RST;
        db_r[i] <= lar_pkg::DEADBAND_RST;
        rt_r[i] <= RESP_W'(lar_pkg::RESP_RST);
      end
      flow_r <= lar_pkg::MAX_FLOW_RST;
      dp_r <= lar_pkg::DP_RST;
      reject_r <= 1'b0;
    end else if (clk_en_i) begin
      sp_r <= sp_nxt;
      db_r <= db_nxt;
      rt_r <= rt_nxt;
      flow_r <= flow_nxt;
      dp_r <= dp_nxt;
      reject_r <= reject_nxt;
    end
  end

  // Acknowledge flash and response tick
  logic [31:0] ack_cnt_r;
  logic [31:0] ack_cnt_nxt;
  logic [31:0] tick_cnt_r;
  logic [31:0] tick_cnt_nxt;
  logic tick;
  // Flash output is a flop of its own so the pin never sees a compare glitch
  logic ack_r;
  logic ack_nxt;

  always_comb begin
    tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));
    tick_cnt_nxt = tick ? 32'h0 : tick_cnt_r + 32'h1;
    if (ack_start) begin
      ack_cnt_nxt = 32'(ACK_CYCLES);
    end else if (ack_cnt_r != 32'h0) begin
      ack_cnt_nxt = ack_cnt_r - 32'h1;
    end else begin
      ack_cnt_nxt = ack_cnt_r;
    end
    ack_nxt = ack_cnt_nxt != 32'h0;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_cnt_r <= 32'h0;
      tick_cnt_r <= 32'h0;
      ack_r <= 1'b0;
    end else if (clk_en_i) begin
      ack_cnt_r <= ack_cnt_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      ack_r <= ack_nxt;
    end
  end

  // Table commit and display variable state machine
  lar_pkg::lar_disp_t disp_r;
  lar_pkg::lar_disp_t disp_nxt;
  logic stored_r;
  logic stored_nxt;

  always_comb begin
    disp_nxt = disp_r;
    stored_nxt = stored_r;
    if (menu_exit_key_i) begin
      stored_nxt = 1'b1;
      disp_nxt = lar_pkg::LAR_DISP_LEVEL;
    end else if (display_variable_key_i && stored_r) begin
      case (disp_r)
        lar_pkg::LAR_DISP_LEVEL: disp_nxt = lar_pkg::LAR_DISP_CONV;
        lar_pkg::LAR_DISP_CONV: disp_nxt = lar_pkg::LAR_DISP_LEVEL;
        default: disp_nxt = lar_pkg::LAR_DISP_LEVEL;
      endcase
    end
    if (key_enter_i && linearization_menu_i) begin
      stored_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      disp_r <= lar_pkg::LAR_DISP_LEVEL;
      stored_r <= 1'b0;
    end else if (clk_en_i) begin
      disp_r <= disp_nxt;
      stored_r <= stored_nxt;
    end
  end

  // Relay channels
  logic [LEVEL_W-1:0] track_level;
  logic [2:0] alarm;
  assign track_level = conv_src ? conv_level_i : pct_level_i;

  for (genvar g = 0; g < 3; g++) begin : g_chan
    lar_relay_chan #(
      .LEVEL_W(LEVEL_W),
      .RESP_W(RESP_W)
    ) u_chan (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .clk_en_i(clk_en_i),
      .tick_i(tick),
      .rising_level_trip_i(rise_sw[g]),
      .setpoint_i(sp_r[g]),
      .deadband_i(db_r[g]),
      .resp_i(rt_r[g]),
      .level_i(track_level),
      .alarm_o(alarm[g])
    );
  end

  // Coil energized means normal; reset and power fail leave all coils off, diag error only coil 2 and only with diag_c
  logic [2:0] coil_r;
  logic [2:0] coil_nxt;

  always_comb begin
    if (pwr_fail) begin
      coil_nxt = 3'h0;
    end else begin
      coil_nxt = ~alarm;
      if (diag_c) begin
        coil_nxt[2] = !diag_err;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      coil_r <= 3'h0;
    end else if (clk_en_i) begin
      coil_r <= coil_nxt;
    end
  end

  assign relay_coil_o = coil_r;
  assign ack_flash_o = ack_r;
  assign entry_reject_o = reject_r;
  assign table_stored_o = stored_r;
  assign show_converted_o = disp_r[1];
  assign decimal_point_o = dp_r;
  assign max_flow_o = flow_r;
endmodule : lar_top

/* File: tb/lar_contacts.sv */
// Relay contact model for the plant alarm circuits
`timescale 1ns/1ps
module lar_contacts (
  // Coil drive
  input wire logic [2:0] relay_coil_i,
  // Contact states
  output logic [2:0] no_closed_o,
  output logic [2:0] nc_closed_o
);
  // A dead coil closes the normally closed side, so lost drive alarms
  assign no_closed_o = relay_coil_i;
  assign nc_closed_o = ~relay_coil_i;
endmodule : lar_contacts

/* File: tb/lar_properties.sv */
// Port checker of the level alarm relay logic
`timescale 1ns/1ps
module lar_properties (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // Faults and keypad
  input wire logic diag_relay_c_i,
  input wire logic diag_error_i,
  input wire logic power_fail_i,
  input wire logic key_enter_i,
  input wire logic [1:0] key_relay_i,
  input wire logic [2:0] key_field_i,
  input wire logic [15:0] key_value_i,
  input wire logic menu_exit_key_i,
  input wire logic linearization_menu_i,
  input wire logic decimal_point_menu_i,
  // Outputs
  input wire logic [2:0] relay_coil_o,
  input wire logic ack_flash_o,
  input wire logic entry_reject_o,
  input wire logic table_stored_o,
  input wire logic [2:0] decimal_point_o,
  input wire logic [15:0] max_flow_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic take;
  logic bad;
  assign take = key_enter_i && clk_en_i && key_relay_i != 2'h3;
  assign bad = key_value_i < lar_pkg::DEADBAND_MIN || key_value_i > lar_pkg::FULL_SCALE;
  property p_db_reject;
    take && key_field_i == lar_pkg::FLD_DEADBAND && bad |=> entry_reject_o;
  endproperty
  a_db_reject: assert property (p_db_reject) else $error("bad deadband kept");
  property p_db_accept;
    take && key_field_i == lar_pkg::FLD_DEADBAND && !bad |=> ack_flash_o && !entry_reject_o;
  endproperty
  a_db_accept: assert property (p_db_accept) else $error("good deadband refused");
  property p_refuse_cause;
    $rose(entry_reject_o) |-> $past(key_enter_i && key_relay_i != 2'h3
      && ((key_field_i == lar_pkg::FLD_DEADBAND && bad) || key_field_i > lar_pkg::FLD_DP));
  endproperty
  a_refuse_cause: assert property (p_refuse_cause) else $error("refusal without bad entry");
  property p_dp_store;
    take && key_field_i == lar_pkg::FLD_DP && decimal_point_menu_i
      |=> decimal_point_o == $past(key_value_i[2:0]) && ack_flash_o;
  endproperty
  a_dp_store: assert property (p_dp_store) else $error("decimal point not stored");
  property p_max_flow;
    take && key_field_i == lar_pkg::FLD_MAX_FLOW && linearization_menu_i |=> max_flow_o == $past(key_value_i);
  endproperty
  a_max_flow: assert property (p_max_flow) else $error("max flow not stored");
  property p_commit;
    menu_exit_key_i && clk_en_i && !key_enter_i |=> table_stored_o;
  endproperty
  a_commit: assert property (p_commit) else $error("table not committed");
  property p_power_fail;
    (power_fail_i && clk_en_i) [*8] |-> relay_coil_o == 3'h0;
  endproperty
  a_power_fail: assert property (p_power_fail) else $error("coil held in power fail");
  property p_diag;
    (diag_relay_c_i && diag_error_i && clk_en_i) [*8] |-> !relay_coil_o[2];
  endproperty
  a_diag: assert property (p_diag) else $error("relay C held on diag error");
  cover property (entry_reject_o);
  cover property ($fell(relay_coil_o[0]));
  cover property (table_stored_o);
endmodule : lar_properties
bind lar_top lar_properties lar_properties_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
  .diag_relay_c_i(diag_relay_c_i), .diag_error_i(diag_error_i), .power_fail_i(power_fail_i),
  .key_enter_i(key_enter_i), .key_relay_i(key_relay_i), .key_field_i(key_field_i), .key_value_i(key_value_i),
  .menu_exit_key_i(menu_exit_key_i), .linearization_menu_i(linearization_menu_i),
  .decimal_point_menu_i(decimal_point_menu_i), .relay_coil_o(relay_coil_o), .ack_flash_o(ack_flash_o),
  .entry_reject_o(entry_reject_o), .table_stored_o(table_stored_o), .decimal_point_o(decimal_point_o),
  .max_flow_o(max_flow_o));

/* File: tb/tb.sv */
// Self-checking bench of the level alarm relay logic
`timescale 1ns/1ps
module tb;
  logic clk = 0;
  logic rst_n = 0;
  logic en = 1;
  logic [15:0] pct = 16'h01f4;
  logic [15:0] conv = 16'h01f4;
  logic src = 0;
  logic [2:0] trip = 0;
  logic diag_c = 0, diag_err = 0, pfail = 0, enter = 0, mexit = 0, dkey = 0, lmenu = 0, dpmenu = 0;
  logic [1:0] krel = 0;
  logic [2:0] kfld = 0;
  logic [15:0] kval = 0;
  logic [2:0] coil, dp, no_c, nc_c;
  logic ack, rej, stored, showc;
  logic [15:0] mflow;
  int fail_count = 0, compares = 0, cycles = 0, db = 50;
  int sp[3] = '{300, 400, 500};
  int alarm[3] = '{0, 0, 0};
  int dbv[6] = '{0, 1001, 1000, 1, 50, 50};
  int lv[4] = '{300, 350, 351, 249};
  logic [2:0] modes[2] = '{3'h2, 3'h5};
  // Short tick and flash keep the run brief
  lar_top #(.TICK_CYCLES(4), .ACK_CYCLES(8)) lar_top_i (.core_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(en),
    .pct_level_i(pct), .conv_level_i(conv), .converted_level_source_i(src), .rising_level_trip_i(trip),
    .diag_relay_c_i(diag_c), .diag_error_i(diag_err), .power_fail_i(pfail), .key_enter_i(enter),
    .key_relay_i(krel), .key_field_i(kfld), .key_value_i(kval), .menu_exit_key_i(mexit),
    .display_variable_key_i(dkey), .linearization_menu_i(lmenu), .decimal_point_menu_i(dpmenu),
    .relay_coil_o(coil), .ack_flash_o(ack), .entry_reject_o(rej), .table_stored_o(stored),
    .show_converted_o(showc), .decimal_point_o(dp), .max_flow_o(mflow));
  lar_contacts lar_contacts_i (.relay_coil_i(coil), .no_closed_o(no_c), .nc_closed_o(nc_c));
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wt(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  // Waits out the last flash so ack reflects this entry only
  task automatic key(int r, logic [2:0] f, int v, logic bad);
    wt(10);
    enter = 1;
    krel = r[1:0];
    kfld = f;
    kval = v[15:0];
    wt(1);
    enter = 0;
    chk("reject", rej, bad);
    chk("ack", ack, !bad);
  endtask : key
  task automatic apply(int l, int c, logic s, logic doit);
    int m;
    pct = l[15:0];
    conv = c[15:0];
    // Source switch lags the levels through its filter, so the old source sees the new levels first
    for (int st = 0; st < 2; st++) begin
      m = ((st == 0) ? src : s) ? c : l;
      for (int r = 0; r < 3; r++) begin
        if (trip[r])
          alarm[r] = (m >= sp[r]) ? 1 : (m < sp[r] - db) ? 0 : alarm[r];
        else
          alarm[r] = (m <= sp[r]) ? 1 : (m > sp[r] + db) ? 0 : alarm[r];
      end
    end
    src = s;
    wt(20);
    if (doit) chk("coil", coil, {alarm[2] == 0, alarm[1] == 0, alarm[0] == 0});
  endtask : apply
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  initial begin
    void'($urandom(32'h51531b13));
    repeat (16) @(posedge clk);
    chk("coil_rst", coil, 0);
    #1 rst_n = 1;
    for (int r = 0; r < 3; r++) key(r, lar_pkg::FLD_SETPOINT, sp[r], 0);
    foreach (dbv[i]) key(i % 2, lar_pkg::FLD_DEADBAND, dbv[i], i < 2);
    key(2, lar_pkg::FLD_DEADBAND, db, 0);
    key(0, 3'h5, 0, 1);
    $display("test keypad done");
    foreach (modes[p]) begin
      trip = modes[p];
      apply(0, 0, 0, 0);
      apply(1000, 1000, 0, 0);
      foreach (lv[i]) apply(lv[i], 0, 0, 1);
      repeat (15) apply($urandom_range(200, 600), $urandom_range(200, 600), $urandom_range(1), 1);
    end
    $display("test hysteresis done");
    key(0, lar_pkg::FLD_RESP, 5, 0);
    apply(0, 0, 0, 1);
    for (int k = 0; k < 3; k++) begin
      pct = k[0] ? 16'h0000 : 16'h0190;
      wt(12);
      chk("delay", coil[0], 1);
    end
    wt(20);
    chk("delay_end", coil[0], 0);
    $display("test delay done");
    diag_c = 1;
    diag_err = 1;
    wt(12);
    chk("diag", coil[2], 0);
    diag_err = 0;
    wt(12);
    chk("diag", coil[2], 1);
    pfail = 1;
    wt(12);
    chk("pfail", coil, 0);
    chk("contacts", nc_c, 3'h7);
    chk("contacts_no", no_c, 3'h0);
    pfail = 0;
    $display("test faults done");
    dpmenu = 1;
    key(0, lar_pkg::FLD_DP, 5, 0);
    chk("dp", dp, 5);
    dpmenu = 0;
    lmenu = 1;
    key(0, lar_pkg::FLD_MAX_FLOW, 3000, 0);
    chk("flow", mflow, 3000);
    chk("stored", stored, 0);
    lmenu = 0;
    mexit = 1;
    wt(1);
    mexit = 0;
    chk("stored", stored, 1);
    chk("show", showc, 0);
    dkey = 1;
    wt(1);
    dkey = 0;
    chk("show", showc, 1);
    en = 0;
    dpmenu = 1;
    enter = 1;
    kfld = lar_pkg::FLD_DP;
    kval = 16'h0002;
    wt(3);
    enter = 0;
    dpmenu = 0;
    en = 1;
    wt(1);
    chk("freeze", dp, 5);
    $display("test table done");
    final_report();
  end
endmodule : tb
